//--- core/dtcr_timer_block.sv
// ----------------------------------------------------------------------
// Dual timer with capture/reload
// ----------------------------------------------------------------------
//
// Local design decision: strobed register access.
module dtcr_timer_block
  import dtcr_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  // External pins
  input  wire logic             aux_count_pin,
  input  wire logic             aux_dir_pin,
  input  wire logic             core_count_pin,
  input  wire logic             core_dir_pin,
  input  wire logic             capture_input_pin,
  input  wire logic             third_count_pin,
  input  wire logic             third_dir_pin,
  // Outputs
  output logic                  core_toggle_out_pin,
  output logic                  aux_irq,
  output logic                  core_irq,
  output logic                  capture_irq
);
  localparam int NPIN = 7;
  localparam int PS_W = $clog2(DTCR_MAX_DIV);

  // One free prescaler serves the basic-clock strobe and both
  // timers. Changing the block code mid-run shifts the tick phase,
  // so software should reprogram it with the timers stopped and
  // clear any flag that a stray event may have set.

  // State apart from tgl_prev_r: control, counts, flags, prescaler and the
  // registered copies of every output
  typedef struct packed {
    logic [15:0]      aux_ctrl;
    logic [15:0]      core_ctrl;
    logic [CNT_W-1:0] aux_cnt;
    logic [CNT_W-1:0] core_cnt;
    logic [CNT_W-1:0] capture_reload;
    logic [2:0]       flags;
    logic [2:0]       irq_en;
    logic [PS_W-1:0]  ps;
    logic [31:0]      rdata;
    logic             tgl_out;
    logic [2:0]       irq;
  } dtcr_state_t;

  dtcr_state_t st_r;
  dtcr_state_t st_nxt;

  // Pin bundle and its sampled views
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic            basic_tick;

  // Packed so one generate loop serves all seven pins
  assign pins = {third_dir_pin, third_count_pin, capture_input_pin, core_dir_pin,
                 core_count_pin, aux_dir_pin, aux_count_pin};

  // ----------------------------------------------------------------------
  // Basic clock strobe
  // ----------------------------------------------------------------------
  // Non-linear block factor: 00->4, 01->2, 10->16, 11->8
  // Returned as log2 so a timer rate is a plain sum of exponents
  function automatic logic [4:0] bps_log(input logic [1:0] code);
    unique case (code)
      2'b00:   bps_log = 5'h2;
      2'b01:   bps_log = 5'h1;
      2'b10:   bps_log = 5'h4;
      default: bps_log = 5'h3;
    endcase
  endfunction

  // Tick when low prescaler bits are all ones, the cycle before they roll over to zero
  // Masked compare avoids a divider per timer; the largest
  // exponent spans the whole prescaler width
  function automatic logic ps_tick(input logic [PS_W-1:0] ps, input logic [4:0] lg);
    logic [PS_W-1:0] m;
    m       = (PS_W'(1) << lg) - PS_W'(1);
    ps_tick = (ps & m) == m;
  endfunction

  // Block code shared by both timers
  logic [1:0] bps;
  assign bps        = st_r.core_ctrl[DTCR_C_BPS_LSB +: 2];
  assign basic_tick = ps_tick(st_r.ps, bps_log(bps));

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // One sampler per pin
  // Pin order: 0 aux count, 1 aux dir, 2 core count,
  // 3 core dir, 4 capture, 5 third count, 6 third dir.
  // Edges lag the pin by two flops plus up to one basic period,
  // so slow pins must hold each level for a full basic period.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      dtcr_edge_sync u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .sample  (basic_tick),
        .pin     (pins[gi]),
        .level   (lvl[gi]),
        .rise    (rise[gi]),
        .fall    (fall[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Per-timer count enable
  // ----------------------------------------------------------------------
  // Evaluates mode, gate, edge select for one timer
  // Gated modes take the count pin level as the gate.
  // Reserved mode codes fall to the default and never count.
  // Counter mode: param bit 0 picks rising, bit 1 falling.
  // Both bits together count every edge.
  function automatic logic count_en(
    input logic [2:0] mode, input logic [2:0] prm, input logic run,
    input logic [PS_W-1:0] ps, input logic [1:0] bcode,
    input logic gate, input logic e_r, input logic e_f);
    logic tt;
    tt = ps_tick(ps, bps_log(bcode) + {2'b00, prm});
    count_en = 1'b0;
    if (run) begin
      unique case (mode)
        DTCR_M_TIMER:   count_en = tt;
        DTCR_M_GATE_LO: count_en = tt & ~gate;
        DTCR_M_GATE_HI: count_en = tt & gate;
        DTCR_M_COUNTER: count_en = (prm[0] & e_r) | (prm[1] & e_f);
        default:        count_en = 1'b0;                             // reserved codes
      endcase
    end
  endfunction

  // Per-cycle decode of the current state
  logic aux_en;
  logic core_en;
  logic aux_dn;
  logic core_dn;
  logic aux_run;
  logic tgl_rise;
  logic tgl_fall;
  logic cap_ev;
  logic aux_wrap;
  logic core_wrap;
  logic [1:0] trig;

  // Toggle latch edges seen one cycle late from the register
  // The lag keeps the aux counter off the core wrap path,
  // traded for one cycle of latency
  logic tgl_prev_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_prev_r <= 1'b0;
    end else begin
      tgl_prev_r <= st_r.core_ctrl[DTCR_C_TGL_BIT];
    end
  end
  assign tgl_rise = st_r.core_ctrl[DTCR_C_TGL_BIT] & ~tgl_prev_r;
  assign tgl_fall = ~st_r.core_ctrl[DTCR_C_TGL_BIT] & tgl_prev_r;

  // Direction, run and enables
  // With UDE set, down exactly when the direction pin differs from the bit; with it clear, the bit alone.
  // Remote run lets one bit start both timers together.
  always_comb begin
    aux_dn  = st_r.aux_ctrl[DTCR_UD_BIT] ^
              (st_r.aux_ctrl[DTCR_UDE_BIT] & lvl[1]);
    core_dn = st_r.core_ctrl[DTCR_UD_BIT] ^
              (st_r.core_ctrl[DTCR_UDE_BIT] & lvl[3]);
    aux_run = st_r.aux_ctrl[DTCR_A_REMOTE_BIT] ? st_r.core_ctrl[DTCR_RUN_BIT]
                                              : st_r.aux_ctrl[DTCR_RUN_BIT];
    if (st_r.aux_ctrl[DTCR_PARAM_LSB + 2]) begin
      aux_en = count_en({1'b0, st_r.aux_ctrl[4:3]}, st_r.aux_ctrl[2:0], aux_run,
                        st_r.ps, bps, lvl[0], tgl_rise, tgl_fall);
    end else begin
      aux_en = count_en({1'b0, st_r.aux_ctrl[4:3]}, st_r.aux_ctrl[2:0], aux_run,
                        st_r.ps, bps, lvl[0], rise[0], fall[0]);
    end
    if ((st_r.core_ctrl[5:3] == DTCR_M_COUNTER) && st_r.core_ctrl[2]) begin
      core_en = 1'b0;
    end else begin
      core_en = count_en(st_r.core_ctrl[5:3], st_r.core_ctrl[2:0],
                         st_r.core_ctrl[DTCR_RUN_BIT], st_r.ps, bps,
                         lvl[2], rise[2], fall[2]);
    end
    // Capture source and edge select
    // Third-timer source: bit 0 any count-pin edge, bit 1 any
    // direction-pin edge
    trig = st_r.aux_ctrl[DTCR_A_TRIG_LSB +: 2];
    if (st_r.aux_ctrl[DTCR_A_THIRD_BIT]) begin
      cap_ev = (trig[0] & (rise[5] | fall[5])) | (trig[1] & (rise[6] | fall[6]));
    end else begin
      cap_ev = (trig[0] & rise[4]) | (trig[1] & fall[4]);
    end
    // Wrap: all ones counting up, zero counting down
    aux_wrap  = aux_en & (aux_dn ? (st_r.aux_cnt == '0) : (&st_r.aux_cnt));
    core_wrap = core_en & (core_dn ? (st_r.core_cnt == '0) : (&st_r.core_cnt));
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Software writes first; hardware events then take priority
  // A count write in the cycle of a count tick is lost: the
  // tick wins, as does a flag set over a flag clear.
  // Reload and clear-on-capture override the plain step,
  // and clear-on-capture overrides a reload in the same cycle.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.ps = st_r.ps + PS_W'(1);

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        DTCR_AUX_CTRL_OFS:  st_nxt.aux_ctrl  = reg_wdata[15:0] & DTCR_AUX_CTRL_MASK;
        DTCR_CORE_CTRL_OFS: st_nxt.core_ctrl = reg_wdata[15:0] & DTCR_CORE_CTRL_MASK;
        DTCR_AUX_CNT_OFS:   st_nxt.aux_cnt   = reg_wdata[CNT_W-1:0];
        DTCR_CORE_CNT_OFS:  st_nxt.core_cnt  = reg_wdata[CNT_W-1:0];
        DTCR_CAPTURE_RELOAD_OFS:    st_nxt.capture_reload    = reg_wdata[CNT_W-1:0];
        DTCR_FLAGS_OFS:     st_nxt.flags     = st_r.flags & ~reg_wdata[2:0];
        DTCR_IRQ_EN_OFS:    st_nxt.irq_en    = reg_wdata[2:0];
        default:            st_nxt.aux_ctrl  = st_nxt.aux_ctrl;
      endcase
    end

    // Aux timer counting
    // Wrap is detected on the old value, before the step
    if (aux_en) begin
      st_nxt.aux_cnt = aux_dn ? st_r.aux_cnt - CNT_W'(1) : st_r.aux_cnt + CNT_W'(1);
    end
    if (aux_wrap) begin
      st_nxt.flags[DTCR_F_AUX] = 1'b1;
    end

    // Core timer counting, reload and toggle
    // Reload replaces the wrapped value, so the period is one tick
    // more than the distance from the reload value to the wrap point
    if (core_en) begin
      st_nxt.core_cnt = core_dn ? st_r.core_cnt - CNT_W'(1) : st_r.core_cnt + CNT_W'(1);
    end
    if (core_wrap) begin
      st_nxt.flags[DTCR_F_CORE] = 1'b1;
      st_nxt.core_ctrl[DTCR_C_TGL_BIT] = ~st_r.core_ctrl[DTCR_C_TGL_BIT];
      if (st_r.core_ctrl[DTCR_C_RELOAD_BIT]) begin
        st_nxt.core_cnt = st_r.capture_reload;
      end
    end

    // Capture event
    // Flag sets on every selected edge, even with capture off
    if (cap_ev) begin
      st_nxt.flags[DTCR_F_CAP] = 1'b1;
      if (st_r.aux_ctrl[DTCR_A_CAP_BIT]) begin
        st_nxt.capture_reload = st_r.aux_cnt;
      end
      if (st_r.aux_ctrl[DTCR_A_CLR_BIT]) begin
        st_nxt.aux_cnt = '0;
      end
      if (st_r.core_ctrl[DTCR_C_CLR_BIT]) begin
        st_nxt.core_cnt = '0;
      end
    end

    // Read data, valid only the cycle after the strobe
    // Zero outside the answer cycle so slaves can share an OR bus
    st_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        DTCR_AUX_CTRL_OFS:  st_nxt.rdata = {16'h0000, st_r.aux_ctrl};
        DTCR_CORE_CTRL_OFS: st_nxt.rdata = {16'h0000, st_r.core_ctrl};
        DTCR_AUX_CNT_OFS:   st_nxt.rdata = 32'(st_r.aux_cnt);
        DTCR_CORE_CNT_OFS:  st_nxt.rdata = 32'(st_r.core_cnt);
        DTCR_CAPTURE_RELOAD_OFS:    st_nxt.rdata = 32'(st_r.capture_reload);
        DTCR_FLAGS_OFS:     st_nxt.rdata = {29'h0, st_r.flags};
        DTCR_IRQ_EN_OFS:    st_nxt.rdata = {29'h0, st_r.irq_en};
        default:            st_nxt.rdata = '0;
      endcase
    end

    // Registered outputs
    // Taken from the next state so pins change on the same edge
    // as the registers they mirror, with no extra cycle of lag;
    // the output is low whenever its enable is clear
    st_nxt.tgl_out = st_nxt.core_ctrl[DTCR_C_OE_BIT] &
                     st_nxt.core_ctrl[DTCR_C_TGL_BIT];
    st_nxt.irq     = st_nxt.flags & st_nxt.irq_en;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Block state apart from tgl_prev_r in one register; async reset to zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output straight from the state register
  assign reg_rdata           = st_r.rdata;
  assign core_toggle_out_pin = st_r.tgl_out;
  assign aux_irq             = st_r.irq[DTCR_F_AUX];
  assign core_irq            = st_r.irq[DTCR_F_CORE];
  assign capture_irq         = st_r.irq[DTCR_F_CAP];
endmodule

//--- core/dtcr_pkg.sv
package dtcr_pkg;
  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] DTCR_AUX_CTRL_OFS  = 8'h14;
  localparam logic [7:0] DTCR_CORE_CTRL_OFS = 8'h18;
  localparam logic [7:0] DTCR_AUX_CNT_OFS   = 8'h2C;
  localparam logic [7:0] DTCR_CORE_CNT_OFS  = 8'h30;
  localparam logic [7:0] DTCR_CAPTURE_RELOAD_OFS    = 8'h34;
  localparam logic [7:0] DTCR_FLAGS_OFS     = 8'h38;
  localparam logic [7:0] DTCR_IRQ_EN_OFS    = 8'h3C;

  // ----------------------------------------------------------------------
  // Core control field positions
  // ----------------------------------------------------------------------
  localparam int DTCR_C_RELOAD_BIT = 15;
  localparam int DTCR_C_CLR_BIT    = 14;
  localparam int DTCR_C_BPS_LSB    = 11;
  localparam int DTCR_C_TGL_BIT    = 10;
  localparam int DTCR_C_OE_BIT     = 9;
  localparam int DTCR_UDE_BIT      = 8;
  localparam int DTCR_UD_BIT       = 7;
  localparam int DTCR_RUN_BIT      = 6;
  localparam int DTCR_MODE_LSB     = 3;
  localparam int DTCR_PARAM_LSB    = 0;

  // ----------------------------------------------------------------------
  // Aux control field positions
  // ----------------------------------------------------------------------
  localparam int DTCR_A_CAP_BIT    = 15;
  localparam int DTCR_A_CLR_BIT    = 14;
  localparam int DTCR_A_TRIG_LSB   = 12;
  localparam int DTCR_A_THIRD_BIT  = 10;
  localparam int DTCR_A_REMOTE_BIT = 9;

  // Writable masks: reserved bits read zero
  localparam logic [15:0] DTCR_CORE_CTRL_MASK = 16'hDFFF;
  localparam logic [15:0] DTCR_AUX_CTRL_MASK  = 16'hF7DF;
  localparam logic [15:0] DTCR_RESET_VAL      = 16'h0000;

  // Flag bit positions
  localparam int DTCR_F_AUX  = 0;
  localparam int DTCR_F_CORE = 1;
  localparam int DTCR_F_CAP  = 2;

  // Mode codes
  localparam logic [2:0] DTCR_M_TIMER   = 3'h0;
  localparam logic [2:0] DTCR_M_COUNTER = 3'h1;
  localparam logic [2:0] DTCR_M_GATE_LO = 3'h2;
  localparam logic [2:0] DTCR_M_GATE_HI = 3'h3;

  // Longest overall divider, for prescaler width
  localparam int DTCR_MAX_DIV = 2048;
endpackage

//--- core/dtcr_edge_sync.sv
// Two-flop synchroniser plus basic-clock sampler with edge outputs
module dtcr_edge_sync
  import dtcr_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Sample strobe
  input  wire logic sample,
  // Pin
  input  wire logic pin,
  // Sampled level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic smp;
    logic rise;
    logic fall;
  } dtcr_es_t;

  dtcr_es_t st_r;
  dtcr_es_t st_nxt;

  // ----------------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------------
  // Edge only when two basic-clock samples differ
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = pin;
    st_nxt.s2   = st_r.s1;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    if (sample) begin
      st_nxt.smp  = st_r.s2;
      st_nxt.rise = st_r.s2 & ~st_r.smp;
      st_nxt.fall = ~st_r.s2 & st_r.smp;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.smp;
  assign rise  = st_r.rise;
  assign fall  = st_r.fall;
endmodule

//--- testbench/dtcr_pins_model.sv
// ----------------------------------------------------------------------
// Far side: count, gate, direction and capture sources
// ----------------------------------------------------------------------
module dtcr_pins_model (
  // Clock
  input  wire logic       clk,
  // Levels toward the block
  output logic      [6:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet levels until the bench asks for edges
  initial pins = 7'h00;

  // Flip selected pins, then hold; hold must cover a sampling period
  task automatic flip(input logic [6:0] mask, input int hold);
    pins <= pins ^ mask;
    repeat (hold) @(posedge clk);
  endtask
endmodule

//--- testbench/dtcr_timer_block_checker.sv
// ----------------------------------------------------------------------
// Port-level checks of the timer block
// ----------------------------------------------------------------------
module dtcr_timer_block_checker
  import dtcr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  // Outputs
  input  wire logic        core_toggle_out_pin,
  input  wire logic        aux_irq,
  input  wire logic        core_irq,
  input  wire logic        capture_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic [3:0] en_r;
  logic [3:0] en1_r;
  logic [3:0] en2_r;
  logic [3:0] off;

  // Enable shadows; history covers the output register delay
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r  <= '0;
      en1_r <= '0;
      en2_r <= '0;
    end else begin
      if (reg_wr && reg_addr == DTCR_IRQ_EN_OFS) begin
        en_r[2:0] <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == DTCR_CORE_CTRL_OFS) begin
        en_r[3] <= reg_wdata[DTCR_C_OE_BIT];
      end
      en1_r <= en_r;
      en2_r <= en1_r;
    end
  end

  // Off only once the enable has been low for three cycles
  assign off = ~(en_r | en1_r | en2_r);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  a_rdata_upper: assert property ($past(reg_rd) |-> reg_rdata[31:16] == '0)
    else $error("upper read bits not zero");
  a_core_resv: assert property ($past(reg_rd && reg_addr == DTCR_CORE_CTRL_OFS)
    |-> !reg_rdata[13])
    else $error("core control bit 13 not zero");
  a_aux_resv: assert property ($past(reg_rd && reg_addr == DTCR_AUX_CTRL_OFS)
    |-> reg_rdata[11] == 1'b0 && reg_rdata[5] == 1'b0)
    else $error("aux control reserved bits not zero");
  a_unmapped_zero: assert property ($past(reg_rd && reg_addr == 8'h00)
    |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (reg_wr && reg_addr == DTCR_CORE_CTRL_OFS ##1
    reg_rd && reg_addr == DTCR_CORE_CTRL_OFS |=> (reg_rdata[15:0] & 16'hDBFF)
    == ($past(reg_wdata, 2) & DTCR_CORE_CTRL_MASK & 16'hDBFF))
    else $error("core control read back differs");
  a_aux_irq_mask: assert property (off[0] |-> !aux_irq)
    else $error("aux interrupt while disabled");
  a_core_irq_mask: assert property (off[1] |-> !core_irq)
    else $error("core interrupt while disabled");
  a_cap_irq_mask: assert property (off[2] |-> !capture_irq)
    else $error("capture interrupt while disabled");
  a_out_gated: assert property (off[3] |-> !core_toggle_out_pin)
    else $error("toggle output driven while disabled");
endmodule

bind dtcr_timer_block dtcr_timer_block_checker i_chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_toggle_out_pin(core_toggle_out_pin), .aux_irq(aux_irq),
  .core_irq(core_irq), .capture_irq(capture_irq)
);

//--- testbench/dtcr_timer_block_tb.sv
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end

module dtcr_timer_block_tb
  import dtcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic [31:0] v;
  logic [6:0]  pins;
  logic [15:0] c;
  logic [15:0] e16;
  logic [2:0]  mode;
  logic        ud;
  logic        ude;
  logic        dn;
  logic        act;
  int          miscompares = 0;
  int          checks = 0;
  int          div;
  logic [7:0]  ra[5] = '{DTCR_AUX_CTRL_OFS, DTCR_CORE_CTRL_OFS, DTCR_AUX_CNT_OFS,
                         DTCR_CORE_CNT_OFS, 8'h00};
  logic [15:0] rm[5] = '{DTCR_AUX_CTRL_MASK, DTCR_CORE_CTRL_MASK, 16'hFFFF, 16'hFFFF,
                         16'h0};
  int          fac[4] = '{4, 2, 16, 8};
  logic [15:0] ecnt[4] = '{16'h0, 16'h2, 16'h2, 16'h4};

  // 100 MHz clock
  always #5 clk = ~clk;

  dtcr_pins_model i_pins (.clk(clk), .pins(pins));

  dtcr_timer_block i_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .aux_count_pin(pins[0]), .aux_dir_pin(pins[1]), .core_count_pin(pins[2]),
    .core_dir_pin(pins[3]), .capture_input_pin(pins[4]),
    .third_count_pin(pins[5]), .third_dir_pin(pins[6]),
    .core_toggle_out_pin(), .aux_irq(), .core_irq(), .capture_irq()
  );

  // ----------------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------------
  // Second write in a row lets an edge pass so the strobe is set once
  task automatic wr(input logic [7:0] a, input logic [31:0] val);
    if (reg_wr === 1'b1) @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= val;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h1A07CE4E));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // Reset state, unmapped place included
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK("reset", 32'h0, d)
    end
    rd(DTCR_CAPTURE_RELOAD_OFS);
    `CHK("reset_capture_reload", 32'h0, d)
    // Random read back; run bits kept low so nothing counts
    repeat (6) begin
      v = $urandom() & 32'hFFFF_FFBF;
      for (int i = 0; i < 5; i++) begin
        wr(ra[i], v);
        rd(ra[i]);
        `CHK("readback", {16'h0, v[15:0] & rm[i]}, d)
      end
    end
    wr(DTCR_AUX_CTRL_OFS, 32'h0);
    // Rate per block code, random direction, gate and mode
    for (int b = 0; b < 4; b++) begin
      mode = 3'($urandom_range(0, 3));
      if (mode == 3'h1) mode = 3'h4;
      ud  = 1'($urandom());
      ude = 1'($urandom());
      if ($urandom_range(0, 1) == 1) i_pins.flip(7'h0C, 40);
      div = fac[b] << b[1:0];
      dn  = ude ? (pins[3] ^ ud) : ud;
      act = mode == 3'h0 || (mode == 3'h2 && !pins[2]) || (mode == 3'h3 && pins[2]);
      wr(DTCR_CORE_CNT_OFS, 32'h0);
      wr(DTCR_CORE_CTRL_OFS, {19'h0, b[1:0], 2'b0, ude, ud, 1'b1, mode, b[2:0]});
      repeat (8 * div) @(posedge clk);
      wr(DTCR_CORE_CTRL_OFS, 32'h0);
      rd(DTCR_CORE_CNT_OFS);
      c = dn ? 16'h0 - d[15:0] : d[15:0];
      `CHK("rate", 1'b1, act ? (c >= 7 && c <= 9) : (c == 0))
    end
    // Wrap with and without reload, interrupt on then off
    for (int k = 0; k < 2; k++) begin
      wr(DTCR_FLAGS_OFS, 32'h7);
      wr(DTCR_IRQ_EN_OFS, {29'h0, {3{k == 0}}});
      wr(DTCR_CAPTURE_RELOAD_OFS, 32'h1234);
      wr(DTCR_CORE_CNT_OFS, 32'hFFFE);
      wr(DTCR_CORE_CTRL_OFS, k == 0 ? 32'h8A40 : 32'h0A40);
      repeat (8) @(posedge clk);
      `CHK("core_irq", k == 0, i_dut.core_irq)
      `CHK("toggle_out", 1'b1, i_dut.core_toggle_out_pin)
      rd(DTCR_CORE_CNT_OFS);
      c = d[15:0] - (k == 0 ? 16'h1234 : 16'h0);
      `CHK("reload", 1'b1, c <= 4)
      rd(DTCR_FLAGS_OFS);
      `CHK("wrap_flag", 1'b1, d[DTCR_F_CORE])
      wr(DTCR_CORE_CTRL_OFS, 32'h0);
    end
    wr(DTCR_FLAGS_OFS, 32'h7);
    rd(DTCR_FLAGS_OFS);
    `CHK("flag_clear", 32'h0, d)
    // Counter mode, every edge code on both timers
    for (int p = 0; p < 4; p++) begin
      wr(DTCR_AUX_CNT_OFS, 32'h0);
      wr(DTCR_CORE_CNT_OFS, 32'h0);
      wr(DTCR_CORE_CTRL_OFS, 32'h0848 | p);
      wr(DTCR_AUX_CTRL_OFS, 32'h0048 | p);
      repeat (4) i_pins.flip(7'h05, 8);
      rd(DTCR_AUX_CNT_OFS);
      `CHK("aux_edges", ecnt[p], d[15:0])
      rd(DTCR_CORE_CNT_OFS);
      `CHK("core_edges", ecnt[p], d[15:0])
    end
    // Aux counts rising toggle latch edges; core wraps every 4 cycles
    wr(DTCR_AUX_CNT_OFS, 32'h0);
    wr(DTCR_AUX_CTRL_OFS, 32'h004D);
    wr(DTCR_CAPTURE_RELOAD_OFS, 32'hFFFE);
    wr(DTCR_CORE_CNT_OFS, 32'hFFFE);
    wr(DTCR_CORE_CTRL_OFS, 32'h8840);
    repeat (80) @(posedge clk);
    wr(DTCR_CORE_CTRL_OFS, 32'h0);
    rd(DTCR_AUX_CNT_OFS);
    `CHK("aux_latch_edges", 1'b1, d[15:0] >= 9 && d[15:0] <= 11)
    wr(DTCR_AUX_CTRL_OFS, 32'h0);
    wr(DTCR_IRQ_EN_OFS, 32'h7);
    // Capture on each trigger code, rise then fall
    for (int t = 0; t < 4; t++) begin
      v = $urandom_range(1, 16'hFFFF);
      wr(DTCR_FLAGS_OFS, 32'h7);
      wr(DTCR_CAPTURE_RELOAD_OFS, 32'h0ABC);
      wr(DTCR_AUX_CNT_OFS, v);
      wr(DTCR_CORE_CNT_OFS, 32'h5555);
      wr(DTCR_CORE_CTRL_OFS, 32'h4800);
      wr(DTCR_AUX_CTRL_OFS, 32'hC000 | (t << 12));
      i_pins.flip(7'h10, 8);
      i_pins.flip(7'h10, 8);
      `CHK("cap_irq", t != 0, i_dut.capture_irq)
      e16 = t == 0 ? 16'h0ABC : (t == 3 ? 16'h0 : v[15:0]);
      rd(DTCR_CAPTURE_RELOAD_OFS);
      `CHK("capture_reload", {16'h0, e16}, d)
      rd(DTCR_AUX_CNT_OFS);
      `CHK("aux_clear", t == 0 ? v[15:0] : 16'h0, d[15:0])
      rd(DTCR_CORE_CNT_OFS);
      `CHK("core_clear", t == 0 ? 16'h5555 : 16'h0, d[15:0])
    end
    // Third-timer sources: count pin on code 01, direction pin on 10
    wr(DTCR_AUX_CNT_OFS, 32'h0321);
    wr(DTCR_AUX_CTRL_OFS, 32'h9400);
    i_pins.flip(7'h20, 8);
    rd(DTCR_CAPTURE_RELOAD_OFS);
    `CHK("third_count_cap", 32'h0321, d)
    wr(DTCR_AUX_CNT_OFS, 32'h0456);
    wr(DTCR_AUX_CTRL_OFS, 32'hA400);
    i_pins.flip(7'h40, 8);
    rd(DTCR_CAPTURE_RELOAD_OFS);
    `CHK("third_dir_cap", 32'h0456, d)
    tally_and_finish();
  end
endmodule
